// ---- design/pll_clock_power_control.sv ----
// Purpose: clock sources, PLLs, dividers, gating and sleep control
// Assumes: oscillator levels arrive synchronous to i_clock
// Notes: APB slave with zero wait states
`timescale 1ns/1ps
`include "pll_clock_power_cfg.svh"
module pll_clock_power_control #(
   parameter logic [15:0] LOCK_CYCLES =
      16'((`PLL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // oscillator levels
   input wire logic i_irc,
   input wire logic i_sysosc,
   input wire logic i_wdosc,
   // wake sources
   input wire logic i_irq,
   input wire logic [`START_N-1:0] i_start,
   // generated clocks
   output logic o_main_clk,
   output logic o_core_clk,
   output logic [1:0] o_per_clk,
   output logic [`GATE_N-1:0] o_per_clk_en,
   output logic o_clock_output_pin,
   output logic o_usb_clk,
   // analog controls
   output clkpwr_pkg::analog_pd_t o_pd,
   output logic [8:0] o_wdosc_cfg
);
   import clkpwr_pkg::*;

   localparam top_state_t RST = '{
      sys: '0,
      usb: '0,
      req: `SRC_IRC,
      act: `SRC_IRC,
      mux: MUX_FOLLOW,
      main: 1'b0,
      cpu_div: `RST_CPU_DIV,
      gate: `RST_GATE,
      per_div: '0,
      co_sel: `SRC_IRC,
      co_div: '0,
      mode: PWR_RUN,
      keep_wd: 1'b0,
      keep_bod: 1'b0,
      start_en: '0,
      wd_cfg: `RST_WD_CFG,
      pd_run: `RST_PD_RUN,
      pd: `RST_PD,
      rdata: '0,
      ready: 1'b0,
      err: 1'b0
   };

   top_state_t q, d;
   logic sys_clk, sys_lock;
   logic usb_lock;
   logic sys_ref;
   logic wr;
   logic wake;
   logic cur_src;

   // ----------------------------------------
   // source pick, shared by main and output mux
   // ----------------------------------------
   function automatic logic pick(input logic [1:0] s, input logic a,
                                 input logic b, input logic c,
                                 input logic e);
      logic r;
      r = a;
      unique case (s)
         2'h0: r = a;
         2'h1: r = b;
         2'h2: r = c;
         2'h3: r = e;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // plls
   // ----------------------------------------
   // system pll runs from rc or system oscillator
   assign sys_ref = q.sys.src ? i_sysosc : i_irc;

   pll_core #(
      .LOCK_CYCLES(LOCK_CYCLES)
   ) u_sys_pll (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_ref(sys_ref),
      .i_en(!q.pd.syspll),
      .i_cfg(q.sys),
      .o_clk(sys_clk),
      .o_lock(sys_lock)
   );

   // usb pll always takes the system oscillator
   pll_core #(
      .LOCK_CYCLES(LOCK_CYCLES)
   ) u_usb_pll (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_ref(i_sysosc),
      .i_en(!q.pd.usbpll),
      .i_cfg(q.usb),
      .o_clk(o_usb_clk),
      .o_lock(usb_lock)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      wr = i_psel && i_penable && q.ready && i_pwrite;
      wake = |(i_start & q.start_en);
      // apb setup cycle: decode and prepare answer
      d.ready = i_psel && !i_penable;
      d.err = 1'b0;
      d.rdata = '0;
      if (d.ready) begin
         case (i_paddr)
            `A_PLL_CTRL: d.rdata = 32'(q.sys);
            `A_PLL_STAT: d.rdata = {30'h0, usb_lock, sys_lock};
            `A_USB_CTRL: d.rdata = 32'(q.usb);
            `A_MAIN_SEL: d.rdata = {27'h0, q.mux, q.act, q.req};
            `A_CPU_DIV: d.rdata = {24'h0, q.cpu_div};
            `A_CLK_GATE: d.rdata = {16'h0, q.gate};
            `A_PER_DIV: d.rdata = {16'h0, q.per_div};
            `A_CLOCK_OUTPUT_PIN: d.rdata = {16'h0, q.co_div, 6'h0, q.co_sel};
            `A_PWR: d.rdata = {26'h0, q.mode, q.keep_bod, q.keep_wd, 2'h0};
            `A_START_LO: d.rdata = q.start_en[31:0];
            `A_START_HI: d.rdata = {24'h0, q.start_en[39:32]};
            `A_WDOSC: d.rdata = {23'h0, q.wd_cfg};
            `A_PD_RUN: d.rdata = {29'h0, q.pd_run};
            default: d.err = 1'b1;
         endcase
      end
      // apb access cycle: writes land here
      if (wr) begin
         case (i_paddr)
            `A_PLL_CTRL: d.sys = pll_cfg_t'(i_pwdata[8:0]);
            `A_USB_CTRL: d.usb = pll_cfg_t'(i_pwdata[8:0]);
            `A_MAIN_SEL: d.req = i_pwdata[1:0];
            `A_CPU_DIV: d.cpu_div = i_pwdata[7:0];
            `A_CLK_GATE: d.gate = i_pwdata[15:0];
            `A_PER_DIV: d.per_div = i_pwdata[15:0];
            `A_CLOCK_OUTPUT_PIN: begin
               d.co_sel = i_pwdata[1:0];
               d.co_div = i_pwdata[15:8];
            end
            `A_PWR: begin
               d.keep_wd = i_pwdata[`PWR_KEEP_WD];
               d.keep_bod = i_pwdata[`PWR_KEEP_BOD];
               if (i_pwdata[`PWR_DEEP]) begin
                  d.mode = PWR_DEEP;
               end else if (i_pwdata[`PWR_SLEEP]) begin
                  d.mode = PWR_SLEEP;
               end
            end
            `A_START_LO: d.start_en[31:0] = i_pwdata;
            `A_START_HI: d.start_en[39:32] = i_pwdata[7:0];
            `A_WDOSC: d.wd_cfg = i_pwdata[8:0];
            `A_PD_RUN: d.pd_run = i_pwdata[2:0];
            default: ;
         endcase
      end
      // power mode wake-up
      unique case (q.mode)
         PWR_RUN: ;
         PWR_SLEEP: begin
            if (i_irq || wake) begin
               d.mode = PWR_RUN;
            end
         end
         PWR_DEEP: begin
            if (wake) begin
               d.mode = PWR_RUN;
            end
         end
         default: d.mode = PWR_RUN;
      endcase
      // analog power-down follows the mode
      if (d.mode == PWR_DEEP) begin
         d.pd.internal_rc_oscillator = 1'b1;
         d.pd.sysosc = 1'b1;
         d.pd.wdosc = !d.keep_wd;
         d.pd.brownout_detector = !d.keep_bod;
         d.pd.syspll = 1'b1;
         d.pd.usbpll = 1'b1;
      end else begin
         d.pd.internal_rc_oscillator = 1'b0;
         d.pd.sysosc = d.pd_run[0];
         d.pd.wdosc = d.pd_run[1];
         d.pd.brownout_detector = d.pd_run[2];
         d.pd.syspll = !d.sys.power;
         d.pd.usbpll = !d.usb.power;
      end
      // glitch-free main clock switch
      cur_src = pick(q.act, i_irc, sys_ref, i_wdosc, sys_clk);
      unique case (q.mux)
         MUX_FOLLOW: begin
            if (q.req != q.act && !q.main && !cur_src) begin
               d.act = q.req;
               d.mux = MUX_PARK;
               d.main = 1'b0;
            end else begin
               d.main = cur_src;
            end
         end
         MUX_PARK: begin
            d.main = 1'b0;
            if (!cur_src) begin
               d.mux = MUX_FOLLOW;
            end
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // dividers and gating
   // ----------------------------------------
   // core clock stops outside run mode
   clk_div #(
      .W(8)
   ) u_cpu_div (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_src(q.main),
      .i_en(q.mode == PWR_RUN),
      .i_div(q.cpu_div),
      .o_out(o_core_clk)
   );

   // peripheral clocks keep running in sleep
   for (genvar g = 0; g < 2; g++) begin : g_per
      clk_div #(
         .W(8)
      ) u_per_div (
         .i_clock(i_clock),
         .i_nrst(i_nrst),
         .i_src(q.main),
         .i_en(q.gate[g]),
         .i_div(q.per_div[8*g +: 8]),
         .o_out(o_per_clk[g])
      );
   end

   // clock output pin selector
   clk_div #(
      .W(8)
   ) u_clock_output_pin_div (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_src(pick(q.co_sel, i_irc, i_sysosc, i_wdosc, q.main)),
      .i_en(1'b1),
      .i_div(q.co_div),
      .o_out(o_clock_output_pin)
   );

   // register-driven outputs
   assign o_main_clk = q.main;
   assign o_per_clk_en = q.gate;
   assign o_pd = q.pd;
   assign o_wdosc_cfg = q.wd_cfg;
   assign o_prdata = q.rdata;
   assign o_pready = q.ready;
   assign o_pslverr = q.err;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   property p_rst_irc;
      disable iff (1'b0)
      !i_nrst |=> (q.act == `SRC_IRC) && (q.req == `SRC_IRC);
   endproperty
   a_rst_irc: assert property (p_rst_irc) else $error("main clock not on rc after reset");

   property p_rst_pll;
      disable iff (1'b0)
      !i_nrst |=> !q.sys.power && q.pd.syspll && !sys_lock;
   endproperty
   a_rst_pll: assert property (p_rst_pll) else $error("pll alive after reset");

   sequence s_sleep_wr;
      wr && (i_paddr == `A_PWR) && i_pwdata[`PWR_SLEEP] && !i_pwdata[`PWR_DEEP];
   endsequence
   property p_sleep_in;
      (s_sleep_wr and (q.mode == PWR_RUN)) |=> (q.mode == PWR_SLEEP);
   endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("sleep write ignored");

   property p_core_stop;
      (q.mode != PWR_RUN && !o_core_clk) |=> !o_core_clk;
   endproperty
   a_core_stop: assert property (p_core_stop) else $error("core clock ran while asleep");

   property p_sleep_wake;
      (q.mode == PWR_SLEEP && i_irq) |=> (q.mode == PWR_RUN);
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("interrupt did not wake");

   property p_deep_pd;
      (q.mode == PWR_DEEP) |-> q.pd.internal_rc_oscillator && q.pd.sysosc && q.pd.syspll && (q.pd.wdosc == !q.keep_wd);
   endproperty
   a_deep_pd: assert property (p_deep_pd) else $error("analog block alive in deep sleep");

   property p_start_wake;
      (q.mode == PWR_DEEP && wake) |=> (q.mode == PWR_RUN);
   endproperty
   a_start_wake: assert property (p_start_wake) else $error("start pin did not wake");

   property p_mux_park;
      (q.mux == MUX_PARK) |-> !q.main;
   endproperty
   a_mux_park: assert property (p_mux_park) else $error("main clock high while parked");

   property p_mux_switch;
      $changed(q.act) |-> !q.main && !$past(q.main);
   endproperty
   a_mux_switch: assert property (p_mux_switch) else $error("source switched mid phase");
endmodule

// ---- design/pll_clock_power_cfg.svh ----
// Purpose: register map, field positions, reset values and timing
// Assumes: APB slave, 200 MHz system clock
// Notes: types live in clkpwr_pkg
`ifndef PLL_CLOCK_POWER_CFG_SVH
`define PLL_CLOCK_POWER_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define A_PLL_CTRL 8'h00
`define A_PLL_STAT 8'h04
`define A_USB_CTRL 8'h08
`define A_MAIN_SEL 8'h0C
`define A_CPU_DIV 8'h10
`define A_CLK_GATE 8'h14
`define A_PER_DIV 8'h18
`define A_CLOCK_OUTPUT_PIN 8'h1C
`define A_PWR 8'h20
`define A_START_LO 8'h24
`define A_START_HI 8'h28
`define A_WDOSC 8'h2C
`define A_PD_RUN 8'h30

// ----------------------------------------
// fields and source codes
// ----------------------------------------
`define PWR_SLEEP 0
`define PWR_DEEP 1
`define PWR_KEEP_WD 2
`define PWR_KEEP_BOD 3
`define SRC_IRC 2'h0
`define SRC_SYS 2'h1
`define SRC_WD 2'h2
`define SRC_PLL 2'h3
`define GATE_N 16
`define START_N 40

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_CPU_DIV 8'h01
`define RST_GATE 16'h001F
`define RST_WD_CFG 9'h020
`define RST_PD_RUN 3'h3
`define RST_PD 6'h1B
`define CLK_PERIOD_NS 5
`define PLL_LOCK_NS 100000

`endif

// ---- design/clkpwr_pkg.sv ----
// Purpose: shared types of the clock and power controller
// Assumes: constants come from pll_clock_power_cfg.svh
// Notes: pll_cfg_t doubles as the layout of both PLL control registers
package clkpwr_pkg;

   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_DEEP = 2'b10
   } pwr_mode_t;

   typedef enum logic {
      MUX_FOLLOW = 1'b0,
      MUX_PARK = 1'b1
   } mux_state_t;

   // pll control word, bit 0 upward: msel, psel, power, src
   typedef struct packed {
      logic src;
      logic power;
      logic [1:0] psel;
      logic [4:0] msel;
   } pll_cfg_t;

   // analog power-down requests, 1 = off
   typedef struct packed {
      logic internal_rc_oscillator;
      logic sysosc;
      logic wdosc;
      logic brownout_detector;
      logic syspll;
      logic usbpll;
   } analog_pd_t;

   typedef struct packed {
      pll_cfg_t sys;
      pll_cfg_t usb;
      logic [1:0] req;
      logic [1:0] act;
      mux_state_t mux;
      logic main;
      logic [7:0] cpu_div;
      logic [15:0] gate;
      logic [15:0] per_div;
      logic [1:0] co_sel;
      logic [7:0] co_div;
      pwr_mode_t mode;
      logic keep_wd;
      logic keep_bod;
      logic [39:0] start_en;
      logic [8:0] wd_cfg;
      logic [2:0] pd_run;
      analog_pd_t pd;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } top_state_t;

endpackage

// ---- design/clk_div.sv ----
// Purpose: clock divider clocked by sampled source edges
// Assumes: i_src is a level sampled by i_clock
// Notes: parks low when disabled; never cuts a phase short
`timescale 1ns/1ps
module clk_div #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // source and control
   input wire logic i_src,
   input wire logic i_en,
   input wire logic [W-1:0] i_div,
   // divided clock
   output logic o_out
);
   typedef struct packed {
      logic src;
      logic [W-1:0] cnt;
      logic out;
   } div_state_t;

   div_state_t q, d;
   logic edge_seen;
   logic run;
   logic [W-1:0] lim;

   // toggle every i_div source edges, so each phase is i_div half periods
   always_comb begin
      d = q;
      d.src = i_src;
      edge_seen = i_src != q.src;
      run = i_en && (i_div != '0);
      lim = (i_div == '0) ? '0 : W'(i_div - 1'b1);
      if (!q.out && !run) begin
         d.cnt = '0;
      end else if (edge_seen) begin
         if (q.cnt >= lim) begin
            d.cnt = '0;
            d.out = ~q.out;
         end else begin
            d.cnt = W'(q.cnt + 1'b1);
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_out = q.out;

   property p_div_cause;
      @(posedge i_clock) disable iff (!i_nrst)
      $changed(o_out) |-> $past(edge_seen);
   endproperty
   a_div_cause: assert property (p_div_cause) else $error("divider moved without a source edge");

   property p_div_stop;
      @(posedge i_clock) disable iff (!i_nrst)
      (!i_en && !o_out) |=> !o_out;
   endproperty
   a_div_stop: assert property (p_div_stop) else $error("gated clock left its low park");
endmodule

// ---- design/pll_core.sv ----
// Purpose: behavioural PLL with lock timer, multiplier and post divider
// Assumes: reference is a sampled level far below i_clock
// Notes: bypasses the reference until locked
`timescale 1ns/1ps
module pll_core #(
   parameter logic [15:0] LOCK_CYCLES = 16'd20000
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // reference and configuration
   input wire logic i_ref,
   input wire logic i_en,
   input wire clkpwr_pkg::pll_cfg_t i_cfg,
   // output clock and lock
   output logic o_clk,
   output logic o_lock
);
   import clkpwr_pkg::*;

   typedef struct packed {
      logic ref_q;
      logic [15:0] per_cnt;
      logic [15:0] per;
      logic have_per;
      logic [18:0] acc;
      logic [15:0] lock_cnt;
      logic lock;
      logic out;
   } pll_state_t;

   pll_state_t q, d;
   logic rise;
   logic thr_hit;
   logic [18:0] thr;
   logic [18:0] sum;

   // measure reference period, count to lock, then run the output NCO
   always_comb begin
      d = q;
      d.ref_q = i_ref;
      rise = i_ref && !q.ref_q;
      thr = 19'({3'h0, q.per} << i_cfg.psel);
      sum = 19'(q.acc + 19'(i_cfg.msel) + 19'h1);
      thr_hit = q.lock && (sum >= thr);
      if (rise) begin
         d.per = 16'(q.per_cnt + 1'b1);
         d.per_cnt = '0;
         d.have_per = 1'b1;
      end else if (q.per_cnt != 16'hFFFF) begin
         d.per_cnt = 16'(q.per_cnt + 1'b1);
      end
      if (q.have_per && !q.lock) begin
         d.lock_cnt = 16'(q.lock_cnt + 1'b1);
         d.lock = (q.lock_cnt == 16'(LOCK_CYCLES - 1'b1));
      end
      if (!q.lock) begin
         // hold the last bypass level on the lock edge, so no phase is cut
         if (!d.lock) begin
            d.out = i_ref;
         end
      end else if (thr_hit) begin
         d.acc = 19'(sum - thr);
         d.out = ~q.out;
      end else begin
         d.acc = sum;
      end
      if (!i_en) begin
         d = '0;
         d.ref_q = i_ref;
         d.out = i_ref;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_clk = q.out;
   assign o_lock = q.lock;

   property p_pll_off;
      @(posedge i_clock) disable iff (!i_nrst)
      !i_en |=> !o_lock;
   endproperty
   a_pll_off: assert property (p_pll_off) else $error("pll locked while disabled");

   sequence s_unlocked2;
      (i_nrst && !o_lock) ##1 !o_lock;
   endsequence
   property p_pll_bypass;
      @(posedge i_clock) disable iff (!i_nrst)
      s_unlocked2 |-> o_clk == $past(i_ref);
   endproperty
   a_pll_bypass: assert property (p_pll_bypass) else $error("unlocked pll not bypassed");

   property p_pll_duty;
      @(posedge i_clock) disable iff (!i_nrst)
      (o_lock && $changed(o_clk)) |-> $past(thr_hit);
   endproperty
   a_pll_duty: assert property (p_pll_duty) else $error("pll output toggled off its half period");
endmodule

// ---- verif/tb_pll_clock_power_control.sv ----
// Purpose: self-checking bench for the clock and power controller
// Assumes: oscillators are levels toggling on i_clock edges
// Notes: short lock count; clock checks count output toggles
`timescale 1ns/1ps
`include "pll_clock_power_cfg.svh"
module tb_pll_clock_power_control;
   import clkpwr_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic i_clock;
   logic i_nrst = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic irq = 1'b0;
   logic internal_rc_oscillator = 1'b0;
   logic sosc = 1'b0;
   logic wosc = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [39:0] start = 40'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, main_clk, core_clk, clock_output_pin, usb_clk, er;
   logic [1:0] per_clk;
   logic [15:0] gate_en;
   analog_pd_t pd;
   logic [8:0] wcfg;
   logic [4:0] sig, prev = 5'h0;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   int c[5] = '{default: 0};
   int d[5];
   assign sig = {usb_clk, clock_output_pin, per_clk[0], core_clk, main_clk};

   pll_clock_power_control #(.LOCK_CYCLES(16'd16)) dut (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_irc(internal_rc_oscillator), .i_sysosc(sosc), .i_wdosc(wosc), .i_irq(irq), .i_start(start),
      .o_main_clk(main_clk), .o_core_clk(core_clk), .o_per_clk(per_clk), .o_per_clk_en(gate_en),
      .o_clock_output_pin(clock_output_pin), .o_usb_clk(usb_clk), .o_pd(pd), .o_wdosc_cfg(wcfg));

   // ----------------------------------------
   // clock, oscillators and toggle counters
   // ----------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   // rc every 4, system every 6, watchdog every 10 cycles
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) internal_rc_oscillator <= ~internal_rc_oscillator;
      if (cyc % 6 == 5) sosc <= ~sosc;
      if (cyc % 10 == 9) wosc <= ~wosc;
      prev <= sig;
      for (int k = 0; k < 5; k++) c[k] <= c[k] + int'(sig[k] !== prev[k]);
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // toggles of each output in sig over n cycles, after a short settle
   task automatic watch(input int n);
      int s[5];
      repeat (20) @(posedge i_clock);
      s = c;
      repeat (n) @(posedge i_clock);
      for (int k = 0; k < 5; k++) d[k] = c[k] - s[k];
   endtask

   task automatic near(input string nm, input int k, input int exp, input int tol);
      chk(nm, (d[k] >= exp - tol && d[k] <= exp + tol) ? exp : d[k], exp);
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      addr <= a;
      wdat <= v;
      @(posedge i_clock);
      pen <= 1'b1;
      @(posedge i_clock);
      while (pready !== 1'b1) begin
         @(posedge i_clock);
      end
      rdat = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic wait_lock(input int b);
      int n;
      n = 0;
      rdat = 32'h0;
      while (rdat[b] !== 1'b1 && n < 60) begin
         apb(1'b0, `A_PLL_STAT, 32'h0);
         n++;
      end
      chk("lock", rdat[b], 1);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("pd", pd, 6'h1B);
      chk("gate", gate_en, 16'h001F);
      chk("wdcfg", wcfg, 9'h020);
      apb(1'b0, `A_PLL_STAT, 32'h0);
      chk("lock", rdat, 32'h0);
      apb(1'b0, `A_MAIN_SEL, 32'h0);
      chk("mainsel", rdat, 32'h0);
      watch(200);
      near("main", 0, 50, 3);
      near("clock_output_pin off", 3, 0, 0);
      apb(1'b0, 8'hFC, 32'h0);
      chk("slverr", er, 1);
      chk("unmapped", rdat, 32'h0);
      apb(1'b1, `A_WDOSC, 32'h1FF);
      chk("wdcfg", wcfg, 9'h1FF);
      $display("test reset done");
   endtask

   task automatic t_clock_output_pin;
      int exp[4] = '{50, 33, 20, 50};
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `A_CLOCK_OUTPUT_PIN, 32'h0100 | k);
         watch(200);
         near("clock_output_pin", 3, exp[k], 3);
      end
      apb(1'b1, `A_MAIN_SEL, 32'h2);
      watch(200);
      near("main wd", 0, 20, 3);
      apb(1'b1, `A_PLL_CTRL, 32'h100);
      apb(1'b1, `A_MAIN_SEL, 32'h1);
      watch(200);
      near("main sys", 0, 33, 3);
      apb(1'b1, `A_MAIN_SEL, 32'h0);
      $display("test clock_output_pin done");
   endtask

   task automatic t_div;
      apb(1'b1, `A_CPU_DIV, 32'h2);
      apb(1'b1, `A_PER_DIV, 32'h0204);
      apb(1'b1, `A_CLK_GATE, 32'h00A5);
      chk("gate", gate_en, 16'h00A5);
      watch(200);
      near("core", 1, 25, 3);
      near("per0", 2, 12, 2);
      chk("per1 gated", per_clk[1], 1'b0);
      apb(1'b1, `A_CLK_GATE, 32'h00A4);
      watch(100);
      near("per0 off", 2, 0, 0);
      apb(1'b1, `A_CLK_GATE, 32'h00A5);
      $display("test div done");
   endtask

   task automatic t_sleep;
      apb(1'b1, `A_PWR, 32'h1);
      watch(200);
      near("core sleep", 1, 0, 0);
      near("per sleep", 2, 12, 2);
      irq <= 1'b1;
      repeat (4) @(posedge i_clock);
      irq <= 1'b0;
      watch(200);
      near("core woke", 1, 25, 3);
      $display("test sleep done");
   endtask

   task automatic t_deep;
      apb(1'b1, `A_MAIN_SEL, 32'h0);
      apb(1'b1, `A_START_HI, 32'h80);
      apb(1'b1, `A_PWR, 32'h6);
      apb(1'b0, `A_PWR, 32'h0);
      chk("pwr", rdat[5:0], 6'h24);
      chk("pd deep", {pd.sysosc, pd.wdosc, pd.brownout_detector, pd.syspll, pd.usbpll}, 5'b10111);
      watch(100);
      near("core deep", 1, 0, 0);
      start[39] <= 1'b1;
      repeat (4) @(posedge i_clock);
      start[39] <= 1'b0;
      watch(200);
      near("core woke", 1, 25, 3);
      apb(1'b0, `A_PWR, 32'h0);
      chk("mode", rdat[5:4], 2'b00);
      $display("test deep done");
   endtask

   task automatic t_usb;
      apb(1'b1, `A_USB_CTRL, 32'h00A7);
      wait_lock(1);
      watch(200);
      near("usb", 4, 67, 3);
      $display("test usb done");
   endtask

   // msel, psel and toggles expected from the rc reference
   task automatic t_pll;
      int tab[4][3] = '{'{7, 3, 25}, '{7, 2, 50}, '{31, 3, 100}, '{0, 0, 25}};
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `A_MAIN_SEL, 32'h0);
         apb(1'b1, `A_PLL_CTRL, 32'h80 | tab[k][0] | (tab[k][1] << 5));
         wait_lock(0);
         apb(1'b1, `A_MAIN_SEL, 32'h3);
         repeat (20) @(posedge i_clock);
         apb(1'b0, `A_MAIN_SEL, 32'h0);
         chk("active", rdat[3:2], 2'h3);
         watch(200);
         near("pll out", 0, tab[k][2], 3);
      end
      $display("test pll done");
   endtask

   // ----------------------------------------
   // sequence, verdict and watchdog
   // ----------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge i_clock);
      i_nrst <= 1'b1;
      @(posedge i_clock);
      t_reset;
      t_clock_output_pin;
      t_div;
      t_sleep;
      t_deep;
      t_usb;
      t_pll;
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge i_clock);
      err_count++;
      end_sim;
   end
endmodule
